// ==== verilog/rcs_consts.svh ====
// Constants for the reservation conflict and sense check block
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define NLUN 2
`define LUN_W 1
`define INIT_W 3
`define NINIT 8
`define ADDR_W 8
`define A_CTRL 8'h00
`define A_CAP 8'h04
`define A_RSEL 8'h08
`define A_RFIRST 8'h0C
`define A_RLAST 8'h10
`define A_STAT 8'h14
`define A_INFO 8'h18
`define C_PRESENT 0
`define C_WPROT 1
`define C_BLANKCHK 2
`define C_DEFPERINIT 3
`define C_MODEPERINIT 4
`define CTRL_RST 32'h0000_0001
`define CAP_RST 32'h0001_0000
`define RS_LUN 0
`define RS_VALID 4
`define RS_WHOLE 5
`define RS_RDEX 6
`define RS_WREX 7
`define RS_HOLD_LO 8
`define RS_HOLD_HI 10
`define SR_ST_LO 0
`define SR_ST_HI 1
`define SR_SK_LO 4
`define SR_SK_HI 7
`define SR_UA_LO 8
`define SR_UA_HI 15
`define SR_LIM 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define UA_ALL 8'hFF
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000
`define LBA_ONE 32'h0000_0001
`endif

// ==== verilog/rcs_pkg.sv ====
// Types shared by the reservation conflict and sense check block
`default_nettype none
`include "rcs_consts.svh"
package rcs_pkg;
  typedef enum logic [1:0] {ST_GOOD, ST_CHECK, ST_CONFLICT} status_e;
  typedef enum logic [3:0] {
    SK_NONE, SK_NOT_READY, SK_ILLEGAL, SK_UNIT_ATTN, SK_HW_ERR, SK_MEDIUM_ERR,
    SK_RECOVERED, SK_ABORTED, SK_DATA_PROTECT, SK_BLANK_CHECK
  } sense_e;
  typedef enum logic [3:0] {
    CC_INQUIRY, CC_REQSENSE, CC_CHGDEF, CC_COPY, CC_UNITOP, CC_PREVENT, CC_NOEXT,
    CC_READCAP, CC_MEDIA, CC_MODESEL, CC_DIAG, CC_REASSIGN, CC_SETLIM, CC_OTHER
  } cmd_class_e;
  typedef enum logic [2:0] {
    EV_UNREC_READ, EV_UNREC_HW, EV_RECOVERED, EV_OVERRUN, EV_BLANK_READ,
    EV_NONBLANK_WR, EV_SELFTEST_FAIL
  } eng_event_e;
  typedef enum logic {RS_IDLE, RS_HOLD} rsp_state_e;
  typedef struct packed {
    cmd_class_e              cmdClass;
    logic [`INIT_W-1:0]      initiator;
    logic [`LUN_W-1:0]       lun;
    logic [`LUN_W-1:0]       dstLun;
    logic                    isRead;
    logic                    isWrite;
    logic                    linked;
    logic                    relAddr;
    logic                    pmi;
    logic                    prevent;
    logic                    affectsExtent;
    logic [31:0]             lba;
    logic [15:0]             count;
    logic [31:0]             dstLba;
  } cmd_s;
  typedef struct packed {
    eng_event_e              event_;
    logic [`INIT_W-1:0]      initiator;
    logic [31:0]             startLba;
    logic [31:0]             lba;
  } eng_s;
  typedef struct packed {
    status_e                 status;
    sense_e                  sense;
    logic                    infoValid;
    logic [31:0]             info;
    logic [31:0]             xfer;
    logic [`INIT_W-1:0]      initiator;
  } rsp_s;
  typedef struct packed {
    logic                    valid;
    logic                    whole;
    logic                    rdExcl;
    logic                    wrExcl;
    logic [`INIT_W-1:0]      holder;
    logic [31:0]             first;
    logic [31:0]             last;
  } resv_s;
  typedef struct packed {
    logic [`LUN_W-1:0]       lun;
    logic [31:0]             first;
    logic [31:0]             last;
  } query_s;
  typedef struct packed {
    logic                    unitOther;
    logic                    extOther;
    logic                    ovAny;
    logic                    ovRw;
  } verdict_s;
  typedef struct packed {
    resv_s [`NLUN-1:0]       ent;
  } tbl_state_s;
  typedef struct packed {
    rsp_state_e              rsState;
    rsp_s                    rsp;
    logic [`NINIT-1:0]       ua;
    logic                    limValid;
    logic [`INIT_W-1:0]      limOwner;
    logic [31:0]             limFirst;
    logic [31:0]             limLast;
    logic [31:0]             ctrl;
    logic [31:0]             cap;
    logic [31:0]             resvFirst;
    logic [31:0]             resvLast;
    logic                    awHeld;
    logic [`ADDR_W-1:0]      awAddr;
    logic                    wHeld;
    logic [31:0]             wData;
    logic [3:0]              wStrb;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    rValid;
    logic [1:0]              rResp;
    logic [31:0]             rData;
  } core_state_s;
endpackage
`default_nettype wire

// ==== verilog/lun_reservation_table.sv ====
// Per logical unit reservation store with two range queries
`default_nettype none
`include "rcs_consts.svh"
module lun_reservation_table (
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    wrEn,
  input  wire logic [`LUN_W-1:0]       wrLun,
  input  wire rcs_pkg::resv_s          wrEntry,
  input  wire logic [`INIT_W-1:0]      qInit,
  input  wire logic                    qRd,
  input  wire logic                    qWr,
  input  wire rcs_pkg::query_s [1:0]   q,
  output var  rcs_pkg::verdict_s [1:0] v
);
  rcs_pkg::tbl_state_s st;
  rcs_pkg::tbl_state_s nxt_st;

  always_comb begin
    nxt_st = st;
    if (wrEn) begin
      nxt_st.ent[wrLun] = wrEntry;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

  // Holder's own commands never see its reservation
  genvar g;
  for (g = 0; g < 2; g++) begin : gQuery
    rcs_pkg::resv_s e;
    logic           other;
    logic           hit;
    assign e     = st.ent[q[g].lun];
    assign other = e.valid && (e.holder != qInit);
    assign hit   = other && !e.whole && (e.first <= q[g].last) && (q[g].first <= e.last);
    assign v[g].unitOther = other && e.whole;
    assign v[g].extOther  = other && !e.whole;
    assign v[g].ovAny     = hit;
    assign v[g].ovRw      = hit && ((qRd && e.rdExcl) || (qWr && e.wrExcl));
  end
endmodule
`default_nettype wire

// ==== verilog/reservation_conflict_and_sense_check.sv ====
// Command screening for reservation conflicts and sense selection
`default_nettype none
`include "rcs_consts.svh"
module reservation_conflict_and_sense_check (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic [`ADDR_W-1:0]    awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [`ADDR_W-1:0]    araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  cmdValid,
  output logic                       cmdReady,
  input  wire rcs_pkg::cmd_s         cmd,
  input  wire logic                  engValid,
  output logic                       engReady,
  input  wire rcs_pkg::eng_s         eng,
  input  wire logic                  mediumChange,
  output logic                       rspValid,
  input  wire logic                  rspReady,
  output rcs_pkg::rsp_s              rsp
);
  rcs_pkg::core_state_s   st;
  rcs_pkg::core_state_s   nxt_st;
  rcs_pkg::query_s [1:0]  q;
  rcs_pkg::verdict_s [1:0] v;
  rcs_pkg::resv_s         tblEntry;
  rcs_pkg::rsp_s          cmdRsp;
  rcs_pkg::rsp_s          engRsp;
  logic                   doWr;
  logic                   tblWrEn;
  logic [31:0]            wMask;
  logic [31:0]            wMerged;
  logic [31:0]            statWord;
  logic [15:0]            cntM1;
  logic [31:0]            last0;
  logic [32:0]            endX;
  logic                   exempt;
  logic                   needMedium;
  logic                   lbaCls;
  logic                   conflict;
  logic                   outOfRange;
  logic [31:0]            firstBad;
  logic                   limHit;
  logic [31:0]            limBad;
  logic                   uaHit;
  logic                   limLoad;
  logic                   limClear;

  // Bus handshakes are combinational; one write and one read in flight
  assign awready  = !st.awHeld;
  assign wready   = !st.wHeld;
  assign bvalid   = st.bValid;
  assign bresp    = st.bResp;
  assign arready  = !st.rValid;
  assign rvalid   = st.rValid;
  assign rdata    = st.rData;
  assign rresp    = st.rResp;
  assign doWr     = st.awHeld && st.wHeld && !st.bValid;

  // Engine reports win the answer slot so a finished transfer never waits on new commands
  assign rspValid = (st.rsState == rcs_pkg::RS_HOLD);
  assign rsp      = st.rsp;
  assign engReady = (st.rsState == rcs_pkg::RS_IDLE);
  assign cmdReady = (st.rsState == rcs_pkg::RS_IDLE) && !engValid;

  genvar b;
  for (b = 0; b < 4; b++) begin : gStrb
    assign wMask[b*8 +: 8] = {8{st.wStrb[b]}};
  end
  assign wMerged = st.wData & wMask;

  // Strobes ignored here: one write commits the whole entry
  assign tblWrEn           = doWr && (st.awAddr == `A_RSEL);
  assign tblEntry.valid    = st.wData[`RS_VALID];
  assign tblEntry.whole    = st.wData[`RS_WHOLE];
  assign tblEntry.rdExcl   = st.wData[`RS_RDEX];
  assign tblEntry.wrExcl   = st.wData[`RS_WREX];
  assign tblEntry.holder   = st.wData[`RS_HOLD_HI:`RS_HOLD_LO];
  assign tblEntry.first    = st.resvFirst;
  assign tblEntry.last     = st.resvLast;

  assign cntM1   = (cmd.count == `CNT_ZERO) ? `CNT_ZERO : cmd.count - `CNT_ONE;
  assign last0   = cmd.lba + {16'h0000, cntM1};
  assign endX    = {1'b0, cmd.lba} + {17'h0_0000, cntM1} + 33'h0_0000_0001;
  assign q[0].lun   = cmd.lun;
  assign q[0].first = cmd.lba;
  assign q[0].last  = last0;
  assign q[1].lun   = cmd.dstLun;
  assign q[1].first = cmd.dstLba;
  assign q[1].last  = cmd.dstLba + {16'h0000, cntM1};

  lun_reservation_table uTable (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wrEn    (tblWrEn),
    .wrLun   (st.wData[`RS_LUN +: `LUN_W]),
    .wrEntry (tblEntry),
    .qInit   (cmd.initiator),
    .qRd     (cmd.isRead),
    .qWr     (cmd.isWrite),
    .q       (q),
    .v       (v)
  );

  always_comb begin
    statWord = '0;
    statWord[`SR_ST_HI:`SR_ST_LO] = st.rsp.status;
    statWord[`SR_SK_HI:`SR_SK_LO] = st.rsp.sense;
    statWord[`SR_UA_HI:`SR_UA_LO] = st.ua;
    statWord[`SR_LIM] = st.limValid;
  end

  // Reservation verdict per command class
  always_comb begin
    exempt = (cmd.cmdClass == rcs_pkg::CC_INQUIRY) ||
             (cmd.cmdClass == rcs_pkg::CC_REQSENSE);
    conflict = 1'b0;
    unique case (cmd.cmdClass)
      rcs_pkg::CC_INQUIRY, rcs_pkg::CC_REQSENSE: begin
        conflict = 1'b0;
      end
      rcs_pkg::CC_CHGDEF: begin
        conflict = v[0].extOther && !st.ctrl[`C_DEFPERINIT];
      end
      rcs_pkg::CC_COPY: begin
        conflict = v[0].ovRw || v[1].ovRw || v[1].unitOther;
      end
      rcs_pkg::CC_UNITOP: begin
        conflict = v[0].extOther;
      end
      rcs_pkg::CC_PREVENT: begin
        conflict = v[0].extOther && cmd.prevent;
      end
      rcs_pkg::CC_NOEXT: begin
        conflict = 1'b0;
      end
      rcs_pkg::CC_READCAP: begin
        conflict = cmd.pmi && v[0].ovRw;
      end
      rcs_pkg::CC_MEDIA: begin
        conflict = v[0].ovRw;
      end
      rcs_pkg::CC_MODESEL: begin
        conflict = v[0].extOther && cmd.affectsExtent &&
                   !st.ctrl[`C_MODEPERINIT];
      end
      rcs_pkg::CC_DIAG: begin
        conflict = v[0].extOther && cmd.affectsExtent;
      end
      rcs_pkg::CC_REASSIGN: begin
        conflict = v[0].ovAny;
      end
      rcs_pkg::CC_SETLIM: begin
        conflict = v[0].ovAny;
      end
      default: begin
        conflict = v[0].ovRw;
      end
    endcase
    if (!exempt && v[0].unitOther) begin
      conflict = 1'b1;
    end
  end

  // Checks around the verdict, in fixed priority: unit attention first, then conflict, then the rest
  always_comb begin
    needMedium = (cmd.cmdClass == rcs_pkg::CC_MEDIA) ||
                 (cmd.cmdClass == rcs_pkg::CC_COPY) ||
                 (cmd.cmdClass == rcs_pkg::CC_OTHER) ||
                 (cmd.cmdClass == rcs_pkg::CC_READCAP) ||
                 (cmd.cmdClass == rcs_pkg::CC_REASSIGN);
    lbaCls = (cmd.cmdClass == rcs_pkg::CC_MEDIA) ||
             (cmd.cmdClass == rcs_pkg::CC_COPY) ||
             (cmd.cmdClass == rcs_pkg::CC_OTHER) ||
             (cmd.cmdClass == rcs_pkg::CC_REASSIGN) ||
             (cmd.cmdClass == rcs_pkg::CC_SETLIM);
    outOfRange = endX > {1'b0, st.cap};
    firstBad = (cmd.lba >= st.cap) ? cmd.lba : st.cap;
    limHit = st.limValid && (st.limOwner == cmd.initiator) && lbaCls &&
             (cmd.cmdClass != rcs_pkg::CC_SETLIM) &&
             ((cmd.lba < st.limFirst) || (last0 > st.limLast));
    limBad = (cmd.lba < st.limFirst) ? cmd.lba : st.limLast + `LBA_ONE;
    uaHit = 1'b0;
    limLoad = 1'b0;
    limClear = st.limValid && (st.limOwner == cmd.initiator) && !cmd.linked;
    cmdRsp = '0;
    cmdRsp.initiator = cmd.initiator;
    cmdRsp.status = rcs_pkg::ST_CHECK;
    cmdRsp.sense = rcs_pkg::SK_ILLEGAL;
    if (!exempt && st.ua[cmd.initiator]) begin
      cmdRsp.sense = rcs_pkg::SK_UNIT_ATTN;
      uaHit = 1'b1;
    end else if (conflict) begin
      cmdRsp.status = rcs_pkg::ST_CONFLICT;
      cmdRsp.sense = rcs_pkg::SK_NONE;
    end else if (cmd.relAddr && !cmd.linked) begin
      cmdRsp.sense = rcs_pkg::SK_ILLEGAL;
    end else if (needMedium && !st.ctrl[`C_PRESENT]) begin
      cmdRsp.sense = rcs_pkg::SK_NOT_READY;
    end else if (lbaCls && outOfRange) begin
      cmdRsp.sense = rcs_pkg::SK_ILLEGAL;
      cmdRsp.infoValid = 1'b1;
      cmdRsp.info = firstBad;
    end else if (limHit) begin
      cmdRsp.sense = rcs_pkg::SK_ILLEGAL;
      cmdRsp.infoValid = 1'b1;
      cmdRsp.info = limBad;
    end else if (needMedium && cmd.isWrite && st.ctrl[`C_WPROT]) begin
      cmdRsp.sense = rcs_pkg::SK_DATA_PROTECT;
    end else begin
      cmdRsp.status = rcs_pkg::ST_GOOD;
      cmdRsp.sense = rcs_pkg::SK_NONE;
      limLoad = (cmd.cmdClass == rcs_pkg::CC_SETLIM) && cmd.linked;
    end
  end

  // Completion reports from the medium engine
  always_comb begin
    engRsp = '0;
    engRsp.initiator = eng.initiator;
    engRsp.status = rcs_pkg::ST_CHECK;
    engRsp.sense = rcs_pkg::SK_ABORTED;
    unique case (eng.event_)
      rcs_pkg::EV_UNREC_READ: begin
        engRsp.sense = rcs_pkg::SK_MEDIUM_ERR;
      end
      rcs_pkg::EV_UNREC_HW: begin
        engRsp.sense = rcs_pkg::SK_HW_ERR;
      end
      rcs_pkg::EV_RECOVERED: begin
        engRsp.sense = rcs_pkg::SK_RECOVERED;
      end
      rcs_pkg::EV_OVERRUN: begin
        engRsp.sense = rcs_pkg::SK_ABORTED;
      end
      rcs_pkg::EV_BLANK_READ: begin
        engRsp.sense = rcs_pkg::SK_BLANK_CHECK;
        engRsp.infoValid = 1'b1;
        engRsp.info = eng.lba;
        engRsp.xfer = eng.lba - eng.startLba;
      end
      rcs_pkg::EV_NONBLANK_WR: begin
        if (st.ctrl[`C_BLANKCHK]) begin
          engRsp.sense = rcs_pkg::SK_BLANK_CHECK;
          engRsp.infoValid = 1'b1;
          engRsp.info = eng.lba;
        end else begin
          engRsp.status = rcs_pkg::ST_GOOD;
          engRsp.sense = rcs_pkg::SK_NONE;
        end
      end
      rcs_pkg::EV_SELFTEST_FAIL: begin
        engRsp.sense = rcs_pkg::SK_HW_ERR;
      end
      default: begin
        engRsp.sense = rcs_pkg::SK_ABORTED;
      end
    endcase
  end

  always_comb begin
    nxt_st = st;
    if (awvalid && awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = wdata;
      nxt_st.wStrb = wstrb;
    end
    if (st.bValid && bready) begin
      nxt_st.bValid = 1'b0;
    end
    if (doWr) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp = `RESP_OKAY;
      case (st.awAddr)
        `A_CTRL: nxt_st.ctrl = (st.ctrl & ~wMask) | wMerged;
        `A_CAP: nxt_st.cap = (st.cap & ~wMask) | wMerged;
        `A_RFIRST: nxt_st.resvFirst = (st.resvFirst & ~wMask) | wMerged;
        `A_RLAST: nxt_st.resvLast = (st.resvLast & ~wMask) | wMerged;
        `A_RSEL, `A_STAT, `A_INFO: nxt_st.bResp = `RESP_OKAY;
        default: nxt_st.bResp = `RESP_SLVERR;
      endcase
    end
    if (st.rValid && rready) begin
      nxt_st.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp = `RESP_OKAY;
      case (araddr)
        `A_CTRL: nxt_st.rData = st.ctrl;
        `A_CAP: nxt_st.rData = st.cap;
        `A_RSEL: nxt_st.rData = '0;
        `A_RFIRST: nxt_st.rData = st.resvFirst;
        `A_RLAST: nxt_st.rData = st.resvLast;
        `A_STAT: nxt_st.rData = statWord;
        `A_INFO: nxt_st.rData = st.rsp.info;
        default: begin
          nxt_st.rData = '0;
          nxt_st.rResp = `RESP_SLVERR;
        end
      endcase
    end
    unique case (st.rsState)
      rcs_pkg::RS_IDLE: begin
        if (engValid) begin
          nxt_st.rsp = engRsp;
          nxt_st.rsState = rcs_pkg::RS_HOLD;
        end else if (cmdValid) begin
          nxt_st.rsp = cmdRsp;
          nxt_st.rsState = rcs_pkg::RS_HOLD;
          if (uaHit) begin
            nxt_st.ua[cmd.initiator] = 1'b0;
          end
          if (limClear && !uaHit) begin
            nxt_st.limValid = 1'b0;
          end
          if (limLoad) begin
            nxt_st.limValid = 1'b1;
            nxt_st.limOwner = cmd.initiator;
            nxt_st.limFirst = cmd.lba;
            nxt_st.limLast = last0;
          end
        end
      end
      rcs_pkg::RS_HOLD: begin
        if (rspReady) begin
          nxt_st.rsState = rcs_pkg::RS_IDLE;
        end
      end
    endcase
    // A medium change in the clearing cycle still leaves attention pending
    if (mediumChange) begin
      nxt_st.ua = `UA_ALL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= '0;
      st.ctrl <= `CTRL_RST;
      st.cap <= `CAP_RST;
      st.ua <= `UA_ALL;
    end else begin
      st <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ==== bench/rcs_check_sva.sv ====
// Handshake and screening assertions for the reservation check block
`default_nettype none
module rcs_check_sva (
  input wire logic          clk_sys,
  input wire logic          nrst,
  input wire logic          bvalid,
  input wire logic          bready,
  input wire logic          rvalid,
  input wire logic          rready,
  input wire logic          cmdValid,
  input wire logic          cmdReady,
  input wire rcs_pkg::cmd_s cmd,
  input wire logic          engValid,
  input wire logic          engReady,
  input wire rcs_pkg::eng_s eng,
  input wire logic          rspValid,
  input wire logic          rspReady,
  input wire rcs_pkg::rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  a_b_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_r_holds: assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped early");
  a_rsp_holds: assert property (rspValid && !rspReady |=> rspValid && $stable(rsp))
    else $error("response changed while held");
  a_cmd_answer: assert property (cmdValid && cmdReady |=> rspValid)
    else $error("no response one cycle after take");
  a_slot_busy: assert property (rspValid |-> !cmdReady && !engReady)
    else $error("work taken while a response is held");
  a_rsp_gap: assert property (rspValid && rspReady |=> !rspValid)
    else $error("response not released after handshake");
  a_check_sense: assert property (
    rspValid && rsp.status == rcs_pkg::ST_CHECK |-> rsp.sense != rcs_pkg::SK_NONE)
    else $error("check condition without sense key");
  a_inquiry_free: assert property (cmdValid && cmdReady &&
    cmd.cmdClass inside {rcs_pkg::CC_INQUIRY, rcs_pkg::CC_REQSENSE}
    |=> rsp.status != rcs_pkg::ST_CONFLICT)
    else $error("inquiry or sense request hit a conflict");
  a_rel_refused: assert property (
    cmdValid && cmdReady && cmd.relAddr && !cmd.linked |=> rsp.status != rcs_pkg::ST_GOOD)
    else $error("unlinked relative address accepted");
  a_unrec_key: assert property (engValid && engReady &&
    eng.event_ == rcs_pkg::EV_UNREC_READ |=> rsp.status == rcs_pkg::ST_CHECK &&
    rsp.sense inside {rcs_pkg::SK_MEDIUM_ERR, rcs_pkg::SK_HW_ERR})
    else $error("unrecovered read with wrong key");
endmodule
bind reservation_conflict_and_sense_check rcs_check_sva checker_i (.*);
`default_nettype wire

// ==== bench/rcs_far_side.sv ====
// Initiator and engine model on the far side of the command port
`default_nettype none
module rcs_far_side (
  input  wire logic          clk_sys,
  input  wire logic          cmdReady,
  input  wire logic          engReady,
  input  wire logic          rspValid,
  input  wire rcs_pkg::rsp_s rsp,
  output var logic           cmdValid,
  output var rcs_pkg::cmd_s  cmd,
  output var logic           engValid,
  output var rcs_pkg::eng_s  eng,
  output var logic           rspReady
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall = 0;
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
    engValid = 1'b0;
    eng = '0;
    rspReady = 1'b0;
  end
  // A slow host keeps the answer waiting; the block must hold it meanwhile
  task automatic collect(output rcs_pkg::rsp_s r);
    repeat (stall) @(posedge clk_sys);
    rspReady <= 1'b1;
    @(posedge clk_sys iff rspValid);
    r = rsp;
    rspReady <= 1'b0;
  endtask
  // Payload is inverted once taken so stale values never look valid
  task automatic issue(input rcs_pkg::cmd_s c, output rcs_pkg::rsp_s r);
    cmd <= c;
    cmdValid <= 1'b1;
    @(posedge clk_sys iff cmdReady);
    cmdValid <= 1'b0;
    cmd <= ~c;
    collect(r);
  endtask
  task automatic report(input rcs_pkg::eng_s e, output rcs_pkg::rsp_s r);
    eng <= e;
    engValid <= 1'b1;
    @(posedge clk_sys iff engReady);
    engValid <= 1'b0;
    eng <= ~e;
    collect(r);
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the reservation conflict and sense check block
`default_nettype none
`include "rcs_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    rcs_pkg::cmd_class_e c;
    logic [2:0]          i;
    logic [2:0]          f;
    logic [31:0]         lba;
    rcs_pkg::status_e    s;
    rcs_pkg::sense_e     k;
    logic [7:0]          inf;
  } row_s;
  localparam rcs_pkg::status_e G = rcs_pkg::ST_GOOD;
  localparam rcs_pkg::status_e C = rcs_pkg::ST_CHECK;
  localparam rcs_pkg::status_e X = rcs_pkg::ST_CONFLICT;
  localparam rcs_pkg::sense_e  N = rcs_pkg::SK_NONE;
  localparam rcs_pkg::sense_e  I = rcs_pkg::SK_ILLEGAL;
  localparam rcs_pkg::sense_e  U = rcs_pkg::SK_UNIT_ATTN;
  logic                  clk_sys = 1'b0;
  logic                  nrst = 1'b0;
  logic [`ADDR_W-1:0]    awaddr = '0, araddr = '0;
  logic [31:0]           wdata = '0;
  logic [3:0]            wstrb = '0;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic                  rready = 1'b0, mediumChange = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid, cmdValid, cmdReady;
  logic                  engValid, engReady, rspValid, rspReady;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  rcs_pkg::cmd_s         cmd;
  rcs_pkg::eng_s         eng;
  rcs_pkg::rsp_s         rsp;
  rcs_pkg::rsp_s         p;
  int                    mismatches = 0, tests_run = 0, cycles = 0;
  // Flags are {linked, relative, affects extent}; holder 1 owns blocks 0A..13
  row_s rows [19] = '{
    '{rcs_pkg::CC_NOEXT, 3'd1, 3'b000, 32'h0000_0000, C, U, 8'h00},
    '{rcs_pkg::CC_NOEXT, 3'd2, 3'b000, 32'h0000_0000, C, U, 8'h00},
    '{rcs_pkg::CC_MEDIA, 3'd2, 3'b000, 32'h0000_000C, X, N, 8'h00},
    '{rcs_pkg::CC_MEDIA, 3'd1, 3'b000, 32'h0000_000C, G, N, 8'h00},
    '{rcs_pkg::CC_INQUIRY, 3'd2, 3'b000, 32'h0000_000C, G, N, 8'h00},
    '{rcs_pkg::CC_NOEXT, 3'd2, 3'b000, 32'h0000_000C, G, N, 8'h00},
    '{rcs_pkg::CC_UNITOP, 3'd2, 3'b000, 32'h0000_0000, X, N, 8'h00},
    '{rcs_pkg::CC_PREVENT, 3'd2, 3'b000, 32'h0000_0000, X, N, 8'h00},
    '{rcs_pkg::CC_COPY, 3'd2, 3'b000, 32'h0000_000F, X, N, 8'h00},
    '{rcs_pkg::CC_CHGDEF, 3'd2, 3'b000, 32'h0000_0000, X, N, 8'h00},
    '{rcs_pkg::CC_MODESEL, 3'd2, 3'b001, 32'h0000_0000, X, N, 8'h00},
    '{rcs_pkg::CC_MODESEL, 3'd2, 3'b000, 32'h0000_0000, G, N, 8'h00},
    '{rcs_pkg::CC_DIAG, 3'd2, 3'b001, 32'h0000_0000, X, N, 8'h00},
    '{rcs_pkg::CC_REASSIGN, 3'd2, 3'b000, 32'h0000_0012, X, N, 8'h00},
    '{rcs_pkg::CC_SETLIM, 3'd2, 3'b100, 32'h0000_000F, X, N, 8'h00},
    '{rcs_pkg::CC_MEDIA, 3'd2, 3'b010, 32'h0000_001E, C, I, 8'h00},
    '{rcs_pkg::CC_MEDIA, 3'd2, 3'b000, 32'h0001_0000, C, I, 8'h00},
    '{rcs_pkg::CC_SETLIM, 3'd1, 3'b100, 32'h0000_0014, G, N, 8'h00},
    '{rcs_pkg::CC_MEDIA, 3'd1, 3'b100, 32'h0000_0020, C, I, 8'h15}};
  reservation_conflict_and_sense_check DUT (.*);
  rcs_far_side far (.*);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin @(posedge clk_sys iff awready); awvalid <= 1'b0; end
      begin @(posedge clk_sys iff wready); wvalid <= 1'b0; end
    join
    // Late ready shows the response is held while unanswered
    @(posedge clk_sys iff bvalid);
    bready <= 1'b1;
    @(posedge clk_sys iff bvalid);
    bready <= 1'b0;
    chk(bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge clk_sys iff arready);
    arvalid <= 1'b0;
    @(posedge clk_sys iff rvalid);
    rready <= 1'b1;
    @(posedge clk_sys iff rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
  endtask
  task automatic run(input row_s r, input logic w);
    rcs_pkg::cmd_s c;
    rcs_pkg::rsp_s q;
    c = '0;
    c.cmdClass = r.c;
    c.initiator = r.i;
    c.isRead = !w;
    c.isWrite = w;
    {c.linked, c.relAddr, c.affectsExtent} = r.f;
    c.prevent = 1'b1;
    c.lba = r.lba;
    c.count = 16'h0001;
    far.issue(c, q);
    chk(q.status, r.s);
    if (r.s == C) chk(q.sense, r.k);
    if (r.k == I && !r.f[1]) chk(q.info, (r.inf != 0) ? 32'(r.inf) : r.lba);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(`A_CAP, `CAP_RST, `RESP_OKAY);
    rd(`A_CTRL, `CTRL_RST, `RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h1C, 32'h0000_0000, `RESP_SLVERR);
    wr(`A_RFIRST, 32'h0000_000A, `RESP_OKAY);
    wr(`A_RLAST, 32'h0000_0013, `RESP_OKAY);
    wr(`A_RSEL, 32'h0000_01D0, `RESP_OKAY);
    foreach (rows[n]) run(rows[n], 1'b0);
    wr(`A_CTRL, 32'h0000_0003, `RESP_OKAY);
    run('{rcs_pkg::CC_MEDIA, 3'd2, 3'b000, 32'h0000_001E, C, rcs_pkg::SK_DATA_PROTECT, 8'h00}, 1'b1);
    wr(`A_CTRL, 32'h0000_0000, `RESP_OKAY);
    run('{rcs_pkg::CC_MEDIA, 3'd2, 3'b000, 32'h0000_001E, C, rcs_pkg::SK_NOT_READY, 8'h00}, 1'b0);
    wr(`A_CTRL, `CTRL_RST, `RESP_OKAY);
    mediumChange <= 1'b1;
    @(posedge clk_sys);
    mediumChange <= 1'b0;
    run('{rcs_pkg::CC_NOEXT, 3'd2, 3'b000, 32'h0000_0000, C, U, 8'h00}, 1'b0);
    far.stall = 2;
    far.report('{rcs_pkg::EV_UNREC_READ, 3'd2, 32'h0000_0005, 32'h0000_0008}, p);
    chk(p.status, C);
    far.report('{rcs_pkg::EV_SELFTEST_FAIL, 3'd2, 32'h0000_0005, 32'h0000_0008}, p);
    chk(p.sense, rcs_pkg::SK_HW_ERR);
    far.report('{rcs_pkg::EV_OVERRUN, 3'd2, 32'h0000_0005, 32'h0000_0008}, p);
    chk(p.sense, rcs_pkg::SK_ABORTED);
    far.report('{rcs_pkg::EV_BLANK_READ, 3'd2, 32'h0000_0005, 32'h0000_0008}, p);
    chk(p.info, 32'h0000_0008);
    chk(p.xfer, 32'h0000_0003);
    close_out();
  end
endmodule
`default_nettype wire
